// ---- hw/rcg_clock_gate.sv ----
// Latch-based glitch-free clock gate
`timescale 1ns/1ns
module rcg_clock_gate
    import rcg_pkg::*;
(
    input  wire logic clk,
    input  wire logic en,
    output wire logic gclk
);

    logic en_q;
    logic en_rise;

    always_latch begin
        if (!clk) begin
            en_q = en;
        end
    end

    assign gclk = clk & en_q;

    always_ff @(posedge clk) begin
        en_rise <= en_q;
    end

    AST_GATE_HELD: assert property (@(negedge clk) en_q == en_rise)
        else $error("gate enable moved while clock high");

    AST_GATE_FOLLOWS: assert property (@(posedge clk) en_q == en)
        else $error("latched enable differs from enable at edge");

endmodule : rcg_clock_gate

// ---- hw/rcg_fault_check.sv ----
// Bus fault detection for accesses to unclocked modules
`timescale 1ns/1ns
module rcg_fault_check
    import rcg_pkg::*;
#(
    parameter int N = NUM_MOD
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [N-1:0]     access_sel,
    input  wire logic [N-1:0]     mod_en,
    output logic                  fault,
    output logic [IDX_W-1:0]      fault_index
);

    if (N < 1 || N > (1 << IDX_W)) begin : g_chk
        $error("rcg_fault_check: N out of range");
    end

    logic [N-1:0] bad;

    assign bad = access_sel & ~mod_en;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault <= 1'b0;
        end else begin
            fault <= |bad;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_index <= '0;
        end else begin
            for (int i = N - 1; i >= 0; i--) begin
                if (bad[i]) begin
                    fault_index <= IDX_W'(i);
                end
            end
        end
    end

    AST_FAULT_ON_GATED: assert property (@(posedge core_clk) disable iff (!rst_n)
        (|(access_sel & ~mod_en)) |=> fault)
        else $error("access to unclocked module gave no fault");

    AST_NO_FAULT_CLOCKED: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((access_sel & ~mod_en) == '0) |=> !fault)
        else $error("fault raised for clocked module");

endmodule : rcg_fault_check

// ---- hw/rcg_top.sv ----
// Run-mode clock gate bank with AHB-Lite register slave
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns
module rcg_top
    import rcg_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic [1:0]         power_state,
    input  wire logic [NUM_MOD-1:0] module_access,
    output logic [NUM_MOD-1:0]      module_clk,
    output logic [NUM_MOD-1:0]      module_clk_en,
    output logic                    module_fault,
    output logic                    irq
);

    logic [31:0]        run_mode_gate_reg;
    logic [31:0]        sleep_mode_gate_reg;
    logic [31:0]        deep_sleep_gate_reg;
    logic [31:0]        run_mode_clock_config;
    logic [31:0]        irq_status;
    logic [31:0]        irq_mask;
    logic [31:0]        next_run_mode_gate_reg;
    logic [31:0]        next_sleep_mode_gate_reg;
    logic [31:0]        next_deep_sleep_gate_reg;
    logic [31:0]        next_run_mode_clock_config;
    logic [31:0]        next_irq_status;
    logic [31:0]        next_irq_mask;
    logic [NUM_MOD-1:0] next_clk_en;
    logic [NUM_MOD-1:0] active_en;
    logic [IDX_W-1:0]   fault_index;
    logic               fault_event;
    logic               auto_gating_select;
    logic               addr_take;
    logic               wr_pend;
    logic [11:0]        wr_ofs;
    logic               first_cycle;
    rcg_pwr_t           pwr;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Bus address phase
    assign addr_take = hsel && htrans[1] && hready;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_ofs  <= '0;
        end else begin
            wr_pend <= addr_take && hwrite;
            if (addr_take) begin
                wr_ofs <= haddr[11:0];
            end
        end
    end

    function automatic logic wr_hit(input logic [11:0] ofs);
        wr_hit = wr_pend && (wr_ofs == ofs);
    endfunction : wr_hit

    always_comb begin
        next_run_mode_gate_reg = run_mode_gate_reg;
        if (wr_hit(RUN_GATE_OFS)) begin
            next_run_mode_gate_reg = hwdata & GATE_WR_MASK;
        end
    end

    always_comb begin
        next_sleep_mode_gate_reg = sleep_mode_gate_reg;
        if (wr_hit(SLEEP_GATE_OFS)) begin
            next_sleep_mode_gate_reg = hwdata & GATE_WR_MASK;
        end
    end

    always_comb begin
        next_deep_sleep_gate_reg = deep_sleep_gate_reg;
        if (wr_hit(DEEP_GATE_OFS)) begin
            next_deep_sleep_gate_reg = hwdata & GATE_WR_MASK;
        end
    end

    always_comb begin
        next_run_mode_clock_config = run_mode_clock_config;
        if (wr_hit(CONFIG_OFS)) begin
            next_run_mode_clock_config = hwdata & (32'h1 << AUTO_GATING_SELECT_BIT);
        end
    end

    // Sticky status, set wins over clear
    always_comb begin
        next_irq_status = irq_status;
        if (wr_hit(IRQ_STAT_OFS)) begin
            next_irq_status = irq_status & ~hwdata;
        end
        if (fault_event) begin
            next_irq_status[FAULT_EVENT_BIT] = 1'b1;
        end
    end

    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_hit(IRQ_MASK_OFS)) begin
            next_irq_mask = hwdata & (32'h1 << FAULT_EVENT_BIT);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_mode_gate_reg   <= GATE_RESET;
            sleep_mode_gate_reg <= GATE_RESET;
            deep_sleep_gate_reg <= GATE_RESET;
        end else begin
            run_mode_gate_reg   <= next_run_mode_gate_reg;
            sleep_mode_gate_reg <= next_sleep_mode_gate_reg;
            deep_sleep_gate_reg <= next_deep_sleep_gate_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_mode_clock_config <= CONFIG_RESET;
        end else begin
            run_mode_clock_config <= next_run_mode_clock_config;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= IRQ_RESET;
            irq_mask   <= IRQ_RESET;
        end else begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
        end
    end

    assign irq = |(irq_status & irq_mask);

    assign auto_gating_select = run_mode_clock_config[AUTO_GATING_SELECT_BIT];

    always_comb begin
        unique case (power_state)
            RCG_SLEEP: pwr = RCG_SLEEP;
            RCG_DEEP:  pwr = RCG_DEEP;
            default:   pwr = RCG_RUN;
        endcase
    end

    always_comb begin
        next_clk_en = rcg_gate_to_en(run_mode_gate_reg);
        if (auto_gating_select) begin
            unique case (pwr)
                RCG_SLEEP: next_clk_en = rcg_gate_to_en(sleep_mode_gate_reg);
                RCG_DEEP:  next_clk_en = rcg_gate_to_en(deep_sleep_gate_reg);
                RCG_RUN:   next_clk_en = rcg_gate_to_en(run_mode_gate_reg);
            endcase
        end
    end

    assign active_en     = next_clk_en;
    assign module_clk_en = active_en;

    for (genvar g = 0; g < NUM_MOD; g++) begin : g_gate
        rcg_clock_gate u_gate (
            .clk  (core_clk),
            .en   (active_en[g]),
            .gclk (module_clk[g])
        );
    end

    rcg_fault_check #(
        .N (NUM_MOD)
    ) u_fault (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .access_sel  (module_access),
        .mod_en      (active_en),
        .fault       (fault_event),
        .fault_index (fault_index)
    );

    assign module_fault = fault_event;

    // Read data captured in address phase
    function automatic logic [31:0] rd_mux(input logic [11:0] ofs);
        unique case (ofs)
            RUN_GATE_OFS:   rd_mux = next_run_mode_gate_reg;
            SLEEP_GATE_OFS: rd_mux = next_sleep_mode_gate_reg;
            DEEP_GATE_OFS:  rd_mux = next_deep_sleep_gate_reg;
            CONFIG_OFS:     rd_mux = next_run_mode_clock_config;
            IRQ_STAT_OFS:   rd_mux = next_irq_status;
            IRQ_MASK_OFS:   rd_mux = next_irq_mask;
            FAULT_ID_OFS:   rd_mux = {28'h0, fault_index};
            ACTIVE_EN_OFS:  rd_mux = {22'h0, active_en};
            default:        rd_mux = RDATA_RESET;
        endcase
    endfunction : rd_mux

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= RDATA_RESET;
        end else if (addr_take && !hwrite) begin
            hrdata <= rd_mux(haddr[11:0]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    sequence s_gate_write(logic [11:0] ofs);
        addr_take && hwrite && (haddr[11:0] == ofs) ##1 1'b1;
    endsequence

    AST_RUN_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_gate_write(RUN_GATE_OFS) |=> run_mode_gate_reg == ($past(hwdata) & GATE_WR_MASK))
        else $error("run gate register did not take the write");

    AST_SLEEP_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_gate_write(SLEEP_GATE_OFS) |=> sleep_mode_gate_reg == ($past(hwdata) & GATE_WR_MASK))
        else $error("sleep gate register did not take the write");

    AST_RESET_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        first_cycle |-> (run_mode_gate_reg == GATE_RESET) && (module_clk_en == '0))
        else $error("gate bank not zero after reset");

    AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((run_mode_gate_reg | sleep_mode_gate_reg | deep_sleep_gate_reg) & ~GATE_WR_MASK) == 32'h0)
        else $error("reserved gate bit set");

    AST_DMA_BIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        !auto_gating_select |-> module_clk_en[NUM_MOD-1] == run_mode_gate_reg[MICRO_DMA_CLOCK_ENABLE_BIT])
        else $error("micro-DMA enable does not follow bit 13");

    AST_AUTO_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
        !auto_gating_select |-> module_clk_en == rcg_gate_to_en(run_mode_gate_reg))
        else $error("sleep settings used without auto gating");

    AST_SLEEP_SEL: assert property (@(posedge core_clk) disable iff (!rst_n)
        auto_gating_select && (power_state == RCG_SLEEP)
        |-> module_clk_en == rcg_gate_to_en(sleep_mode_gate_reg))
        else $error("sleep gate set not applied in sleep");

    AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault_event && irq_mask[FAULT_EVENT_BIT] |=> irq)
        else $error("unmasked fault did not raise interrupt");

endmodule : rcg_top

// ---- include/rcg_pkg.sv ----
// Constants and types for the run-mode clock gate bank
//
// Summary of operation
// - A set gate bit clocks its module; a clear bit leaves it unclocked.
// - Accessing a module whose clock is off answers with a bus fault.
// - The run gate register resets to zero, so every module starts unclocked.
// - Bit 13 is the read/write clock enable of the micro-DMA unit.
// - Bits 8 to 0 enable the clocks of ports J down to A.
// - Bits 31:14 and 12:9 are read-only zero; software preserves them.
// - Run register governs normal running; sleep and deep-sleep registers share its layout.
// - Sleep registers apply only with auto gating selected; else run enables stay.
// - Sleep gate register sits at 0x118, same layout, reset zero.
package rcg_pkg;

    localparam int          NUM_MOD        = 10;
    localparam int          IDX_W          = 4;

    localparam logic [11:0] RUN_GATE_OFS   = 12'h108;
    localparam logic [11:0] SLEEP_GATE_OFS = 12'h118;
    localparam logic [11:0] DEEP_GATE_OFS  = 12'h128;
    localparam logic [11:0] CONFIG_OFS     = 12'h140;
    localparam logic [11:0] IRQ_STAT_OFS   = 12'h144;
    localparam logic [11:0] IRQ_MASK_OFS   = 12'h148;
    localparam logic [11:0] FAULT_ID_OFS   = 12'h14C;
    localparam logic [11:0] ACTIVE_EN_OFS  = 12'h150;

    localparam int          PORT_A_CLOCK_ENABLE_BIT    = 0;
    localparam int          PORT_J_CLOCK_ENABLE_BIT    = 8;
    localparam int          MICRO_DMA_CLOCK_ENABLE_BIT = 13;
    localparam int          AUTO_GATING_SELECT_BIT     = 0;
    localparam int          FAULT_EVENT_BIT            = 0;

    localparam logic [31:0] GATE_WR_MASK   = 32'h000021FF;
    localparam logic [31:0] GATE_RESET     = 32'h00000000;
    localparam logic [31:0] CONFIG_RESET   = 32'h00000000;
    localparam logic [31:0] IRQ_RESET      = 32'h00000000;
    localparam logic [31:0] RDATA_RESET    = 32'h00000000;

    typedef enum logic [1:0] {
        RCG_RUN   = 2'h0,
        RCG_SLEEP = 2'h1,
        RCG_DEEP  = 2'h3
    } rcg_pwr_t;

    // Gate register bits to per-module enables, ports first, micro-DMA last
    function automatic logic [NUM_MOD-1:0] rcg_gate_to_en(input logic [31:0] gate);
        rcg_gate_to_en = {gate[MICRO_DMA_CLOCK_ENABLE_BIT],
                          gate[PORT_J_CLOCK_ENABLE_BIT:PORT_A_CLOCK_ENABLE_BIT]};
    endfunction : rcg_gate_to_en

endpackage : rcg_pkg

// ---- tb/rcg_periph_model.sv ----
// Peripheral side model: counts gated clock edges, issues accesses
`timescale 1ns/1ns
module rcg_periph_model
    import rcg_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic [NUM_MOD-1:0] module_clk,
    output logic [NUM_MOD-1:0]      module_access,
    output logic [7:0]              clk_cnt [NUM_MOD]
);
    logic [NUM_MOD-1:0] prev;

    initial begin
        prev = '0;
        module_access = '0;
        clk_cnt = '{default: 8'h00};
    end

    always @(module_clk) begin
        for (int i = 0; i < NUM_MOD; i++) begin
            if (module_clk[i] && !prev[i]) begin
                clk_cnt[i] = clk_cnt[i] + 8'h01;
            end
        end
        prev = module_clk;
    end

    task automatic touch(input int idx);
        module_access <= NUM_MOD'(1) << idx;
        @(posedge core_clk);
        module_access <= '0;
    endtask : touch
endmodule : rcg_periph_model

// ---- tb/run_mode_clock_gate_bank_test.sv ----
// Self-checking bench for the run-mode clock gate bank
`timescale 1ns/1ns
module run_mode_clock_gate_bank_test
    import rcg_pkg::*;
;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] wd;
        logic [31:0] rexp;
        logic [9:0]  en;
    } rcg_row_t;

    logic               core_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               hsel = 1'b0;
    logic               hwrite = 1'b0;
    logic [1:0]         htrans = 2'h0;
    logic [1:0]         power_state = 2'h0;
    logic [31:0]        haddr = 32'h0;
    logic [31:0]        hwdata = 32'h0;
    logic [31:0]        rd;
    logic [31:0]        hrdata;
    logic               hreadyout;
    logic               hresp;
    logic               module_fault;
    logic               irq;
    logic [NUM_MOD-1:0] module_access;
    logic [NUM_MOD-1:0] module_clk;
    logic [NUM_MOD-1:0] module_clk_en;
    logic [7:0]         clk_cnt [NUM_MOD];
    logic [7:0]         snap [NUM_MOD];
    int                 failures = 0;
    int                 n_tests = 0;

    rcg_row_t rows [7] = '{
        '{RUN_GATE_OFS, 32'hFFFFFFFF, 32'h000021FF, 10'h3FF},
        '{RUN_GATE_OFS, 32'h00002000, 32'h00002000, 10'h200},
        '{RUN_GATE_OFS, 32'h00000155, 32'h00000155, 10'h155},
        '{SLEEP_GATE_OFS, 32'hFFFFFFFF, 32'h000021FF, 10'h155},
        '{DEEP_GATE_OFS, 32'h00000003, 32'h00000003, 10'h155},
        '{12'h1F0, 32'hFFFFFFFF, 32'h00000000, 10'h155},
        '{CONFIG_OFS, 32'h00000001, 32'h00000001, 10'h155}
    };
    logic [1:0] ps_tab [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h1};
    logic [9:0] en_tab [5] = '{10'h3FF, 10'h003, 10'h155, 10'h155, 10'h155};

    always #5 core_clk = ~core_clk;

    rcg_top rcg_top_i (
        .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .power_state, .module_access, .module_clk, .module_clk_en, .module_fault, .irq
    );

    rcg_periph_model rcg_periph_model_i (
        .core_clk, .module_clk, .module_access, .clk_cnt
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) failures++;
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk

    task automatic test_done();
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #100000;
        failures++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rchk(RUN_GATE_OFS, 32'h0);
        chk(module_clk_en, 10'h000);
        chk(hresp, 1'b0);
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, rows[i].a, rows[i].wd);
            rchk(rows[i].a, rows[i].rexp);
            chk(module_clk_en, rows[i].en);
        end
        rchk(ACTIVE_EN_OFS, 32'h155);
        for (int i = 0; i < 5; i++) begin
            if (i == 4) bus(1'b1, CONFIG_OFS, 32'h0);
            power_state <= ps_tab[i];
            @(posedge core_clk);
            chk(module_clk_en, en_tab[i]);
        end
        power_state <= 2'h0;
        @(negedge core_clk);
        snap = clk_cnt;
        repeat (20) @(negedge core_clk);
        for (int i = 0; i < NUM_MOD; i++) begin
            chk(8'(clk_cnt[i] - snap[i]), (10'h155 >> i) & 1 ? 8'd20 : 8'd0);
        end
        @(posedge core_clk);
        rcg_periph_model_i.touch(0);
        @(negedge core_clk);
        chk(module_fault, 1'b0);
        @(posedge core_clk);
        rcg_periph_model_i.touch(1);
        @(negedge core_clk);
        chk(module_fault, 1'b1);
        chk(irq, 1'b0);
        @(negedge core_clk);
        chk(module_fault, 1'b0);
        @(posedge core_clk);
        rchk(FAULT_ID_OFS, 32'h1);
        rchk(IRQ_STAT_OFS, 32'h1);
        bus(1'b1, IRQ_MASK_OFS, 32'h1);
        rchk(IRQ_MASK_OFS, 32'h1);
        chk(irq, 1'b1);
        bus(1'b1, IRQ_STAT_OFS, 32'h1);
        rchk(IRQ_STAT_OFS, 32'h0);
        chk(irq, 1'b0);
        rcg_periph_model_i.touch(9);
        @(negedge core_clk);
        chk(module_fault, 1'b1);
        @(negedge core_clk);
        chk(module_fault, 1'b0);
        chk(irq, 1'b1);
        @(posedge core_clk);
        rchk(FAULT_ID_OFS, 32'h9);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(module_clk_en, 10'h000);
        chk(irq, 1'b0);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rchk(RUN_GATE_OFS, 32'h0);
        rchk(SLEEP_GATE_OFS, 32'h0);
        test_done();
    end
endmodule : run_mode_clock_gate_bank_test
